// [pbfmux_top.v]
// Pin function mux for port B bits 4-7 and port F bits 9-15
//
// Operation
// [R1] Each port B pin 4..7 can be set by software as a GPIO input or output.
// [R2] Address lines 20..23 float while the external bus idles when the bus drive hold bit is clear.
// [R3] Port B pins 4..7 can show prescaler, main, double and oscillator clocks in that order.
// [R4] After reset port B pins 4..7 are GPIO inputs, with the address side floating.
// [R5] Each port B peripheral enable bit hands its pin from GPIO to the alternate function.
// [R6] For released port B pins the clock output select bit picks address line or clock.
// [R7] Port B pins 4..7 can carry address lines 20..23.
// [R8] Data lines 0..6 float while the external bus idles when the bus drive hold bit is clear.
// [R9] Each port F pin 9..15 can be set by software as a GPIO input or output.
// [R10] After reset port F pins 9..15 belong to the external memory data bus.
// [R11] Clearing a port F pull-up enable bit turns off the pull-up on the pin with the same index.
// [R12] Each pin's function is chosen independently of every other pin.
`timescale 1ns/10ps
`default_nettype none
`include "pbfmux_defines.vh"

module pbfmux_top
#(
  parameter NB = 4,
  parameter NF = 7
)
(
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Register port
  input wire [`PBFMUX_ADDR_W-1:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // External memory interface side
  input wire [NB-1:0] EXT_ADDR_HI,
  input wire [NF-1:0] EXT_DATA_OUT,
  input wire EXT_DATA_DIR_OUT,
  input wire EXT_BUS_ACTIVE,
  output wire [NF-1:0] EXT_DATA_IN,
  output wire EXT_CTRL_OE_N,
  // Clocks to monitor
  input wire PRESCALER_CLOCK,
  input wire SYSTEM_MAIN_CLOCK,
  input wire SYSTEM_DOUBLE_CLOCK,
  input wire OSCILLATOR_CLOCK,
  // Port B pins 4..7
  input wire [NB-1:0] PB_IN,
  output wire [NB-1:0] PB_OUT,
  output wire [NB-1:0] PB_OE_N,
  // Port F pins 9..15
  input wire [NF-1:0] PF_IN,
  output wire [NF-1:0] PF_OUT,
  output wire [NF-1:0] PF_OE_N,
  output wire [NF-1:0] PF_PULLUP_EN
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [NB-1:0] b_per_r;
  reg [NB-1:0] b_per_nxt;
  reg [NB-1:0] b_ddr_r;
  reg [NB-1:0] b_ddr_nxt;
  reg [NB-1:0] b_dout_r;
  reg [NB-1:0] b_dout_nxt;
  reg [NB-1:0] clksel_r;
  reg [NB-1:0] clksel_nxt;
  reg [NF-1:0] f_per_r;
  reg [NF-1:0] f_per_nxt;
  reg [NF-1:0] f_ddr_r;
  reg [NF-1:0] f_ddr_nxt;
  reg [NF-1:0] f_dout_r;
  reg [NF-1:0] f_dout_nxt;
  reg [NF-1:0] f_pur_r;
  reg [NF-1:0] f_pur_nxt;
  reg bus_drive_hold_r;
  reg bus_drive_hold_nxt;
  reg [15:0] rdata_nxt;
  wire [NB-1:0] mon_clk;
  wire [NB-1:0] b_alt_out;
  wire addr_drive;
  wire data_drive;
  wire wr_b_per;
  wire wr_b_ddr;
  wire wr_b_dout;
  wire wr_clksel;
  wire wr_f_per;
  wire wr_f_ddr;
  wire wr_f_dout;
  wire wr_f_pur;
  wire wr_busctl;

  // ----------------------------------------
  // Field helpers
  // ----------------------------------------
  // Pad bit i of port F is pin 9+i, so registers use bits 15..9
  function [15:0] place_f;
    input [NF-1:0] v;
    begin
      place_f = {v, 9'h000};
    end
  endfunction

  // Pad bit i of port B is pin 4+i, so registers use bits 7..4
  function [15:0] place_b;
    input [NB-1:0] v;
    begin
      place_b = {8'h00, v, 4'h0};
    end
  endfunction

  function [NB-1:0] take_b;
    input [15:0] d;
    begin
      take_b = d[7:4];
    end
  endfunction

  function [NF-1:0] take_f;
    input [15:0] d;
    begin
      take_f = d[15:9];
    end
  endfunction

  // Unmapped indices match nothing, so their writes fall away
  function hit;
    input [`PBFMUX_ADDR_W-1:0] a;
    input [`PBFMUX_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign wr_b_per = WR & hit(ADDR, `PBFMUX_OFS_B_PER); // R5
  assign wr_b_ddr = WR & hit(ADDR, `PBFMUX_OFS_B_DDR); // R1
  assign wr_b_dout = WR & hit(ADDR, `PBFMUX_OFS_B_DOUT); // R1
  assign wr_clksel = WR & hit(ADDR, `PBFMUX_OFS_CLKSEL); // R6
  assign wr_f_per = WR & hit(ADDR, `PBFMUX_OFS_F_PER); // R10
  assign wr_f_ddr = WR & hit(ADDR, `PBFMUX_OFS_F_DDR); // R9
  assign wr_f_dout = WR & hit(ADDR, `PBFMUX_OFS_F_DOUT); // R9
  assign wr_f_pur = WR & hit(ADDR, `PBFMUX_OFS_F_PUR); // R11
  assign wr_busctl = WR & hit(ADDR, `PBFMUX_OFS_BUSCTL); // R2 R8

  // ----------------------------------------
  // Next register values
  // ----------------------------------------
  always @*
  begin
    b_per_nxt = b_per_r;
    b_ddr_nxt = b_ddr_r;
    b_dout_nxt = b_dout_r;
    clksel_nxt = clksel_r;
    f_per_nxt = f_per_r;
    f_ddr_nxt = f_ddr_r;
    f_dout_nxt = f_dout_r;
    f_pur_nxt = f_pur_r;
    bus_drive_hold_nxt = bus_drive_hold_r;
    if (wr_b_per)
    begin
      b_per_nxt = take_b(WDATA); // R5
    end
    if (wr_b_ddr)
    begin
      b_ddr_nxt = take_b(WDATA); // R1
    end
    if (wr_b_dout)
    begin
      b_dout_nxt = take_b(WDATA); // R1
    end
    if (wr_clksel)
    begin
      clksel_nxt = take_b(WDATA); // R6
    end
    if (wr_f_per)
    begin
      f_per_nxt = take_f(WDATA); // R10
    end
    if (wr_f_ddr)
    begin
      f_ddr_nxt = take_f(WDATA); // R9
    end
    if (wr_f_dout)
    begin
      f_dout_nxt = take_f(WDATA); // R9
    end
    if (wr_f_pur)
    begin
      f_pur_nxt = take_f(WDATA); // R11
    end
    if (wr_busctl)
    begin
      bus_drive_hold_nxt = WDATA[`PBFMUX_BUSCTL_HOLD_BIT]; // R2 R8
    end
  end

  // Every register loads its next value on each edge; reset holds the start state
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      b_per_r <= `PBFMUX_RST_B_PER; // R4
      b_ddr_r <= `PBFMUX_RST_B_DDR; // R4
      b_dout_r <= {NB{1'b0}};
      clksel_r <= `PBFMUX_RST_CLKSEL;
      f_per_r <= `PBFMUX_RST_F_PER; // R10
      f_ddr_r <= `PBFMUX_RST_F_DDR;
      f_dout_r <= {NF{1'b0}};
      f_pur_r <= `PBFMUX_RST_F_PUR;
      bus_drive_hold_r <= `PBFMUX_RST_HOLD;
    end
    else
    begin
      b_per_r <= b_per_nxt;
      b_ddr_r <= b_ddr_nxt;
      b_dout_r <= b_dout_nxt;
      clksel_r <= clksel_nxt;
      f_per_r <= f_per_nxt;
      f_ddr_r <= f_ddr_nxt;
      f_dout_r <= f_dout_nxt;
      f_pur_r <= f_pur_nxt;
      bus_drive_hold_r <= bus_drive_hold_nxt;
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  always @*
  begin
    rdata_nxt = 16'h0000;
    case (ADDR)
      `PBFMUX_OFS_B_PER: rdata_nxt = place_b(b_per_r);
      `PBFMUX_OFS_B_DDR: rdata_nxt = place_b(b_ddr_r);
      `PBFMUX_OFS_B_DOUT: rdata_nxt = place_b(b_dout_r);
      `PBFMUX_OFS_B_PIN: rdata_nxt = place_b(PB_IN);
      `PBFMUX_OFS_CLKSEL: rdata_nxt = place_b(clksel_r);
      `PBFMUX_OFS_F_PER: rdata_nxt = place_f(f_per_r);
      `PBFMUX_OFS_F_DDR: rdata_nxt = place_f(f_ddr_r);
      `PBFMUX_OFS_F_DOUT: rdata_nxt = place_f(f_dout_r);
      `PBFMUX_OFS_F_PIN: rdata_nxt = place_f(PF_IN);
      `PBFMUX_OFS_F_PUR: rdata_nxt = place_f(f_pur_r);
      `PBFMUX_OFS_BUSCTL: rdata_nxt = {15'h0000, bus_drive_hold_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
      RDATA <= 16'h0000;
    else if (RD)
      RDATA <= rdata_nxt;
    else
      RDATA <= 16'h0000;
  end

  // ----------------------------------------
  // Pin muxing
  // ----------------------------------------
  // Clocks pass combinationally; registering them would divide them
  assign mon_clk = {OSCILLATOR_CLOCK, SYSTEM_DOUBLE_CLOCK, SYSTEM_MAIN_CLOCK, PRESCALER_CLOCK}; // R3
  assign b_alt_out = clksel_r & mon_clk | ~clksel_r & EXT_ADDR_HI; // R6 R7
  // Address and control float on idle bus unless hold is set; reset forces float
  assign addr_drive = ~RST & (EXT_BUS_ACTIVE | bus_drive_hold_r); // R2 R4
  assign data_drive = addr_drive & EXT_DATA_DIR_OUT; // R8
  assign EXT_CTRL_OE_N = ~addr_drive; // R2 R8
  assign EXT_DATA_IN = PF_IN;
  assign PF_PULLUP_EN = f_pur_r; // R11

  genvar i;
  generate
    for (i = 0; i < NB; i = i + 1)
    begin : g_b
      // Clock monitor drives regardless of bus state
      pbfmux_pad u_pad (
        .alt_sel(b_per_r[i]), // R5 R12
        .gpio_dir_out(b_ddr_r[i] & ~RST), // R1 R4
        .gpio_dout(b_dout_r[i]),
        .alt_dout(b_alt_out[i]),
        .alt_drive(clksel_r[i] | addr_drive), // R2 R6
        .pad_out(PB_OUT[i]),
        .pad_oe_n(PB_OE_N[i])
      );
    end
    for (i = 0; i < NF; i = i + 1)
    begin : g_f
      pbfmux_pad u_pad (
        .alt_sel(f_per_r[i]), // R10 R12
        .gpio_dir_out(f_ddr_r[i]), // R9
        .gpio_dout(f_dout_r[i]),
        .alt_dout(EXT_DATA_OUT[i]),
        .alt_drive(data_drive), // R8
        .pad_out(PF_OUT[i]),
        .pad_oe_n(PF_OE_N[i])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// [pbfmux_defines.vh]
// Register offsets, field positions and reset values for the port B/F pin mux
`ifndef PBFMUX_DEFINES_VH
`define PBFMUX_DEFINES_VH

// ----------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------
`define PBFMUX_ADDR_W 4
`define PBFMUX_OFS_B_PER 4'h0
`define PBFMUX_OFS_B_DDR 4'h1
`define PBFMUX_OFS_B_DOUT 4'h2
`define PBFMUX_OFS_B_PIN 4'h3
`define PBFMUX_OFS_CLKSEL 4'h4
`define PBFMUX_OFS_F_PER 4'h5
`define PBFMUX_OFS_F_DDR 4'h6
`define PBFMUX_OFS_F_DOUT 4'h7
`define PBFMUX_OFS_F_PIN 4'h8
`define PBFMUX_OFS_F_PUR 4'h9
`define PBFMUX_OFS_BUSCTL 4'ha

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PBFMUX_BUSCTL_HOLD_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PBFMUX_RST_B_PER 4'h0
`define PBFMUX_RST_B_DDR 4'h0
`define PBFMUX_RST_CLKSEL 4'h0
`define PBFMUX_RST_F_PER 7'h7f
`define PBFMUX_RST_F_DDR 7'h00
`define PBFMUX_RST_F_PUR 7'h7f
`define PBFMUX_RST_HOLD 1'h0

`endif

// [pbfmux_pad.v]
// One bidirectional pad cell: chooses between GPIO and alternate drive
`timescale 1ns/10ps
`default_nettype none

module pbfmux_pad
(
  // Selection
  input wire alt_sel,
  input wire gpio_dir_out,
  input wire gpio_dout,
  // Alternate function
  input wire alt_dout,
  input wire alt_drive,
  // Pad
  output wire pad_out,
  output wire pad_oe_n
);

  // ----------------------------------------
  // Drive choice
  // ----------------------------------------
  // Active-low enable: low while the pad is driven
  assign pad_out = alt_sel ? alt_dout : gpio_dout;
  assign pad_oe_n = alt_sel ? ~alt_drive : ~gpio_dir_out;

endmodule

`default_nettype wire

// [pbfmux_monitor.sv]
// Port assertions for the port B/F pin mux
`timescale 1ns/10ps
`default_nettype none
module pbfmux_monitor (
  // Clock, reset and register port
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Bus and pins
  input wire logic EXT_BUS_ACTIVE,
  input wire logic EXT_CTRL_OE_N,
  input wire logic [6:0] EXT_DATA_IN,
  input wire logic [3:0] PB_IN,
  input wire logic [3:0] PB_OE_N,
  input wire logic [6:0] PF_IN,
  input wire logic [6:0] PF_PULLUP_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Mirror of drive hold, since register state is not visible from the ports
  logic hold_r;
  always @(posedge CLK or posedge RST)
    if (RST)
      hold_r <= 1'b0;
    else if (WR && ADDR == 4'ha)
      hold_r <= WDATA[0];
  AST_RST: assert property ($fell(RST) |-> PB_OE_N == 4'hf && PF_PULLUP_EN == 7'h7f) else $error("reset");
  AST_CTL_ON: assert property (EXT_BUS_ACTIVE || hold_r |-> !EXT_CTRL_OE_N) else $error("ctrl");
  AST_CTL_OFF: assert property (!EXT_BUS_ACTIVE && !hold_r |-> EXT_CTRL_OE_N) else $error("float");
  AST_DIN: assert property (EXT_DATA_IN == PF_IN) else $error("data in");
  AST_PB_RD: assert property (RD && ADDR == 4'h3 |=> RDATA == {8'h00, $past(PB_IN), 4'h0}) else $error("pb");
  AST_PF_RD: assert property (RD && ADDR == 4'h8 |=> RDATA == {$past(PF_IN), 9'h000}) else $error("pf");
  AST_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000) else $error("rdata");
  AST_UNMAP: assert property (RD && ADDR > 4'ha |=> RDATA == 16'h0000) else $error("unmapped");
endmodule
bind pbfmux_top pbfmux_monitor mon (.*);
`default_nettype wire

// [pbfmux_mem.sv]
// Behavioural external memory on the port F data pins
`timescale 1ns/10ps
`default_nettype none
module pbfmux_mem #(parameter logic [6:0] RD_VAL = 7'h2a) (
  // Bus state
  input wire logic CLK,
  input wire logic EXT_BUS_ACTIVE,
  input wire logic EXT_DATA_DIR_OUT,
  // Pins
  input wire logic [6:0] PF_OUT,
  input wire logic [6:0] PF_OE_N,
  input wire logic [6:0] PF_PULLUP_EN,
  output var logic [6:0] PF_IN
);
  logic [6:0] last = 7'h00;
  // A released line without pull-up, outside a memory read, shows the inverse of its last level, never a held value
  always_comb
    for (int i = 0; i < 7; i++)
      PF_IN[i] = !PF_OE_N[i] ? PF_OUT[i] : (EXT_BUS_ACTIVE && !EXT_DATA_DIR_OUT) ? RD_VAL[i] :
        PF_PULLUP_EN[i] ? 1'b1 : ~last[i];
  always @(posedge CLK)
    last <= PF_IN;
endmodule
`default_nettype wire

// [pbfmux_top_tb.sv]
// Self-checking bench for the port B/F pin mux
`timescale 1ns/10ps
`default_nettype none
module pbfmux_top_tb;
  logic CLK = 0, RST = 1, WR = 0, RD = 0, EXT_BUS_ACTIVE = 0, EXT_DATA_DIR_OUT = 0, EXT_CTRL_OE_N;
  logic PRESCALER_CLOCK = 0, SYSTEM_MAIN_CLOCK = 1, SYSTEM_DOUBLE_CLOCK = 0, OSCILLATOR_CLOCK = 0;
  logic [3:0] ADDR = 0, EXT_ADDR_HI = 0, PB_OUT, PB_OE_N;
  logic [15:0] WDATA = 0, RDATA;
  logic [6:0] EXT_DATA_OUT = 0, EXT_DATA_IN, PF_IN, PF_OUT, PF_OE_N, PF_PULLUP_EN;
  int n_mismatch = 0, total_checks = 0;
  wire logic [3:0] PB_IN = (~PB_OE_N & PB_OUT) | (PB_OE_N & 4'ha);
  initial forever #12.5 CLK = ~CLK;
  pbfmux_top uut (.*);
  pbfmux_mem mem (.*);
  task c(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK) {WR, ADDR, WDATA} <= {1'b1, a, d};
    @(posedge CLK) WR <= 0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge CLK) {RD, ADDR} <= {1'b1, a};
    @(posedge CLK) RD <= 0;
    #1 c("RDATA", e, RDATA);
  endtask
  task t_reset;
    c("PB_OE_N", 4'hf, PB_OE_N);
    c("PF_OE_N", 7'h7f, PF_OE_N);
    c("PF_PULLUP_EN", 7'h7f, PF_PULLUP_EN);
    rd(4'h5, 16'hfe00);
  endtask
  task t_gpio_b;
    wr(4'h1, 16'h0050);
    wr(4'h2, 16'h0010);
    c("PB_OE_N", 4'ha, PB_OE_N);
    c("PB_OUT", 1, PB_OUT & 4'h5);
    rd(4'h3, 16'h00b0);
  endtask
  task t_alt_b;
    wr(4'h0, 16'h00f0);
    wr(4'h4, 16'h00c0);
    @(posedge CLK) {EXT_BUS_ACTIVE, EXT_ADDR_HI, OSCILLATOR_CLOCK} <= 6'h27;
    #1 c("PB_OUT", 4'hb, PB_OUT);
    c("PB_OE_N", 0, PB_OE_N);
    @(posedge CLK) EXT_BUS_ACTIVE <= 0;
    #1 c("PB_OE_N", 4'h3, PB_OE_N);
    wr(4'ha, 16'h0001);
    c("PB_OE_N", 0, PB_OE_N);
  endtask
  task t_port_f;
    wr(4'ha, 0);
    @(posedge CLK) {EXT_BUS_ACTIVE, EXT_DATA_DIR_OUT, EXT_DATA_OUT} <= 9'h1d5;
    #1 c("PF_OUT", 7'h55, PF_OUT);
    @(posedge CLK) EXT_BUS_ACTIVE <= 0;
    #1 c("PF_OE_N", 7'h7f, PF_OE_N);
    @(posedge CLK) {EXT_BUS_ACTIVE, EXT_DATA_DIR_OUT} <= 2'b10;
    #1 c("EXT_DATA_IN", 7'h2a, EXT_DATA_IN);
    wr(4'h5, 0);
    wr(4'h6, 16'h0200);
    wr(4'h7, 16'h0200);
    c("PF_OE_N", 7'h7e, PF_OE_N);
    rd(4'h8, 16'h5600);
    wr(4'h9, 16'h0200);
    c("PF_PULLUP_EN", 7'h01, PF_PULLUP_EN);
    rd(4'hf, 0);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    #1;
    t_reset;
    t_gpio_b;
    t_alt_b;
    t_port_f;
    print_verdict;
  end
endmodule
`default_nettype wire
